// File: ists_i2c_master.sv
`timescale 1ns/1ns
`default_nettype none
module ists_i2c_master (
    input wire logic mclk,
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end
    task automatic quarter();
        repeat (8) @(posedge mclk);
    endtask
    // Rise waits for the slave to let go; bounded so a stuck stretch cannot hang
    task automatic xbit(input logic b, output logic s);
        sda_low <= !b;
        quarter();
        scl_low <= 1'b0;
        for (int i = 0; i < 4000 && scl !== 1'b1; i++) @(posedge mclk);
        quarter();
        s = sda;
        scl_low <= 1'b1;
        quarter();
    endtask
    task automatic start();
        sda_low <= 1'b1;
        quarter();
        scl_low <= 1'b1;
        quarter();
    endtask
    task automatic stop();
        sda_low <= 1'b1;
        quarter();
        scl_low <= 1'b0;
        quarter();
        sda_low <= 1'b0;
        quarter();
    endtask
    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
            output logic ack_out);
        for (int i = 7; i >= 0; i--) xbit(d[i], q[i]);
        xbit(ack_in, ack_out);
    endtask
endmodule // ists_i2c_master
`default_nettype wire

// File: ists_pkg.sv
//Contract
//- Address match wakes device when wake enable set
//- Ninth clock SDA sampled into receive-ack flag
//- Transmit while ack; on no-ack release SDA
//- START is SDA fall with SCL high; busy
//- Seven address bits MSB first compared
//- Match sets match flag and interrupt
//- Eighth bit stored as master-read flag
//- Matched address acknowledged low on ninth clock
//- Data bytes eight bits, MSB first
//- Receiver drives ack value on ninth clock
//- SCL held until data write or read
//- Single data register for receive and transmit
//- One interrupt: match, byte done, timeout
//- Timeout counter: match starts, SCL fall clears
//- Timeout when count exceeds configured period
//- Timeout stops, disables, flags, interrupts, resets bus
//- Timeout resets only status register to defaults
//- Period is (setting+1) times 32 subclocks
//- Transfer-done low during byte, high after
//- STOP clears bus busy flag
//- Debounce none, two or four clocks
package ists_pkg;

    localparam logic [4:0] ADDR_MODE_CONTROL = 5'h00;
    localparam logic [4:0] ADDR_BUS_STATUS = 5'h04;
    localparam logic [4:0] ADDR_OWN_ADDRESS = 5'h08;
    localparam logic [4:0] ADDR_SHARED_DATA = 5'h0c;
    localparam logic [4:0] ADDR_TIMEOUT_CONTROL = 5'h10;

    typedef struct packed {
        logic [2:0] interface_mode_code;
        logic uart_select;
        logic [1:0] debounce_select;
        logic unit_enable;
        logic spi_incomplete;
    } ists_mode_type;

    typedef struct packed {
        logic transfer_done_flag;
        logic addr_match_flag;
        logic bus_busy_flag;
        logic transmit_direction;
        logic tx_ack_value;
        logic master_read_flag;
        logic addr_match_wake_en;
        logic rx_ack_flag;
    } ists_status_type;

    typedef struct packed {
        logic timeout_enable;
        logic timeout_flag;
        logic [5:0] timeout_period_sel;
    } ists_timeout_type;

    localparam ists_mode_type MODE_POR = '{3'h7, 1'h0, 2'h0, 1'h0, 1'h0};
    localparam ists_status_type STATUS_POR = '{1'h1, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h0, 1'h1};
    localparam ists_timeout_type TIMEOUT_POR = '{1'h0, 1'h0, 6'h00};
    localparam logic [7:0] OWN_ADDRESS_POR = 8'h00;
    localparam logic [2:0] MODE_I2C_SLAVE = 3'h6;

    localparam logic [3:0] BYTE_BITS = 4'h8;
    localparam int SUB_DIVIDE = 32;
    localparam logic [4:0] SUB_DIVIDE_LAST = 5'(SUB_DIVIDE - 1);

    localparam logic [2:0] DEBOUNCE_NONE = 3'h0;
    localparam logic [2:0] DEBOUNCE_TWO = 3'h2;
    localparam logic [2:0] DEBOUNCE_FOUR = 3'h4;

    localparam int PIN_SCL = 0;
    localparam int PIN_SDA = 1;
    localparam int PIN_SUB = 2;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_HOLD,
        ST_RX_BITS,
        ST_RX_ACK,
        ST_TX_BITS,
        ST_TX_ACK,
        ST_WAIT_STOP
    } ists_state_type;

    function automatic logic [2:0] debounce_need(input logic [1:0] sel);
        if (sel[1]) begin
            return DEBOUNCE_FOUR;
        end else if (sel[0]) begin
            return DEBOUNCE_TWO;
        end
        return DEBOUNCE_NONE;
    endfunction

endpackage

// File: ists_properties.sv
`timescale 1ns/1ns
`default_nettype none
module ists_properties
    import ists_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    input wire logic [31:0] AVS_READDATA,
    input wire logic AVS_WAITREQUEST,
    input wire logic SCL_IN,
    input wire logic SCL_OUT,
    input wire logic SCL_OE,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic SUB_CLK,
    input wire logic LOW_POWER,
    input wire logic WAKE,
    input wire logic IRQ
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);

    scl_low_only_a: assert property (SCL_OUT == 1'b0)
        else $error("SCL output value not low");
    sda_low_only_a: assert property (SDA_OUT == 1'b0)
        else $error("SDA output value not low");
    one_wait_a: assert property ($rose(AVS_READ || AVS_WRITE) |->
        AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bus wait not one cycle");
    idle_no_wait_a: assert property (!(AVS_READ || AVS_WRITE) |-> !AVS_WAITREQUEST)
        else $error("wait raised without request");
    irq_pulse_a: assert property (IRQ |=> !IRQ)
        else $error("interrupt longer than one cycle");
    wake_with_irq_a: assert property (WAKE |-> IRQ)
        else $error("wake without match interrupt");
    wake_awake_a: assert property (!LOW_POWER [*3] |-> !WAKE)
        else $error("wake while not in low power");
    // Data may only move while the clock is low, or it reads as start or stop
    sda_moves_low_a: assert property ($changed(SDA_OE) |-> !SCL_IN)
        else $error("data line changed with clock high");
    stretch_free_sda_a: assert property (SCL_OE |-> !SDA_OE)
        else $error("data pulled while clock held");
endmodule // ists_properties
bind ists_slave ists_properties u_ists_properties (
    .MCLK(MCLK), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .SCL_IN(SCL_IN), .SCL_OUT(SCL_OUT), .SCL_OE(SCL_OE),
    .SDA_IN(SDA_IN), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE), .SUB_CLK(SUB_CLK),
    .LOW_POWER(LOW_POWER), .WAKE(WAKE), .IRQ(IRQ));
`default_nettype wire

// File: ists_slave.sv
`timescale 1ns/1ns
`default_nettype none
module ists_slave
    import ists_pkg::*;
(
    input wire logic MCLK,
    input wire logic RST_N,
    input wire logic [4:0] AVS_ADDRESS,
    input wire logic AVS_READ,
    input wire logic AVS_WRITE,
    input wire logic [31:0] AVS_WRITEDATA,
    output logic [31:0] AVS_READDATA,
    output logic AVS_WAITREQUEST,
    input wire logic SCL_IN,
    output logic SCL_OUT,
    output logic SCL_OE,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic SUB_CLK,
    input wire logic LOW_POWER,
    output logic WAKE,
    output logic IRQ
);

    // Input conditioning: SCL, SDA and the subclock
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] sync3;
    logic [2:0] filt;
    logic [2:0] filt_d;
    logic [2:0][2:0] dcnt;
    logic [2:0] next_sync1;
    logic [2:0] next_sync2;
    logic [2:0] next_sync3;
    logic [2:0] next_filt;
    logic [2:0][2:0] next_dcnt;

    // Register bus
    logic ack;
    logic [31:0] rdata;
    logic next_ack;
    logic [31:0] next_rdata;

    // Protocol and register state
    ists_state_type state;
    ists_state_type next_state;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic [7:0] data_reg;
    logic [7:0] next_data_reg;
    logic [7:0] own_address_reg;
    logic [7:0] next_own_address_reg;
    ists_mode_type mode_control_reg;
    ists_mode_type next_mode_control_reg;
    ists_status_type bus_status_control_reg;
    ists_status_type next_bus_status_control_reg;
    ists_timeout_type timeout_control_reg;
    ists_timeout_type next_timeout_control_reg;
    logic [4:0] sub_div;
    logic [4:0] next_sub_div;
    logic [6:0] tmo_cnt;
    logic [6:0] next_tmo_cnt;
    logic tmo_run;
    logic next_tmo_run;
    logic scl_hold;
    logic next_scl_hold;
    logic sda_low;
    logic next_sda_low;
    logic irq;
    logic next_irq;
    logic wake;
    logic next_wake;

    logic req;
    logic accept;
    logic wr_mode;
    logic wr_status;
    logic wr_own;
    logic wr_data;
    logic wr_timeout;
    logic rd_data;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;
    logic i2c_on;
    logic sub_tick;
    logic timeout_evt;
    logic [7:0] shifted_in;

    // Conditioning: a change is seen once the second and third stages agree and the debounce count is met
    always_comb begin
        logic cand;
        logic [2:0] need;
        cand = 1'b0;
        need = DEBOUNCE_NONE;
        next_sync1 = {SUB_CLK, SDA_IN, SCL_IN};
        next_sync2 = sync1;
        next_sync3 = sync2;
        next_filt = filt;
        next_dcnt = dcnt;
        for (int i = 0; i < 3; i++) begin
            cand = (sync2[i] == sync3[i]) ? sync2[i] : filt[i];
            need = (i == PIN_SUB) ? DEBOUNCE_NONE
                                  : debounce_need(mode_control_reg.debounce_select);
            if (cand == filt[i]) begin
                next_dcnt[i] = 3'h0;
            end else if (dcnt[i] >= need) begin
                next_filt[i] = cand;
                next_dcnt[i] = 3'h0;
            end else begin
                next_dcnt[i] = dcnt[i] + 3'h1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            sync3 <= 3'h7;
            filt <= 3'h7;
            filt_d <= 3'h7;
            dcnt <= '0;
        end else begin
            sync1 <= next_sync1;
            sync2 <= next_sync2;
            sync3 <= next_sync3;
            filt <= next_filt;
            filt_d <= filt;
            dcnt <= next_dcnt;
        end
    end

    assign scl_rise = filt[PIN_SCL] & ~filt_d[PIN_SCL];
    assign scl_fall = ~filt[PIN_SCL] & filt_d[PIN_SCL];
    // SDA moving while SCL stays high
    assign start_cond = ~filt[PIN_SDA] & filt_d[PIN_SDA] & filt[PIN_SCL] & filt_d[PIN_SCL];
    assign stop_cond = filt[PIN_SDA] & ~filt_d[PIN_SDA] & filt[PIN_SCL] & filt_d[PIN_SCL];
    assign sub_tick = filt[PIN_SUB] & ~filt_d[PIN_SUB] & (sub_div == SUB_DIVIDE_LAST);

    // Avalon slave: one wait cycle, then the answer
    assign req = AVS_READ | AVS_WRITE;
    assign accept = req & ack;
    assign AVS_WAITREQUEST = req & ~ack;
    assign AVS_READDATA = rdata;
    assign wr_mode = accept & AVS_WRITE & (AVS_ADDRESS == ADDR_MODE_CONTROL);
    assign wr_status = accept & AVS_WRITE & (AVS_ADDRESS == ADDR_BUS_STATUS);
    assign wr_own = accept & AVS_WRITE & (AVS_ADDRESS == ADDR_OWN_ADDRESS);
    assign wr_data = accept & AVS_WRITE & (AVS_ADDRESS == ADDR_SHARED_DATA);
    assign wr_timeout = accept & AVS_WRITE & (AVS_ADDRESS == ADDR_TIMEOUT_CONTROL);
    assign rd_data = accept & AVS_READ & (AVS_ADDRESS == ADDR_SHARED_DATA);

    always_comb begin
        next_ack = req & ~ack;
        next_rdata = rdata;
        if (req & ~ack) begin
            case (AVS_ADDRESS)
                ADDR_MODE_CONTROL: next_rdata = {24'h000000, mode_control_reg};
                ADDR_BUS_STATUS: next_rdata = {24'h000000, bus_status_control_reg};
                ADDR_OWN_ADDRESS: next_rdata = {24'h000000, own_address_reg};
                ADDR_SHARED_DATA: next_rdata = {24'h000000, data_reg};
                ADDR_TIMEOUT_CONTROL: next_rdata = {24'h000000, timeout_control_reg};
                default: next_rdata = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ack <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    assign i2c_on = mode_control_reg.unit_enable & ~mode_control_reg.uart_select
                    & (mode_control_reg.interface_mode_code == MODE_I2C_SLAVE);
    assign shifted_in = {shreg[6:0], filt[PIN_SDA]};
    // Overflow once the count passes the selected period
    assign timeout_evt = timeout_control_reg.timeout_enable & tmo_run
                         & (tmo_cnt > {1'b0, timeout_control_reg.timeout_period_sel});

    always_comb begin
        next_state = state;
        next_bit_cnt = bit_cnt;
        next_shreg = shreg;
        next_data_reg = data_reg;
        next_own_address_reg = own_address_reg;
        next_mode_control_reg = mode_control_reg;
        next_bus_status_control_reg = bus_status_control_reg;
        next_timeout_control_reg = timeout_control_reg;
        next_sub_div = sub_div;
        next_tmo_cnt = tmo_cnt;
        next_tmo_run = tmo_run;
        next_irq = 1'b0;
        next_wake = 1'b0;

        if (wr_mode) begin
            next_mode_control_reg = ists_mode_type'(AVS_WRITEDATA[7:0]);
        end
        if (wr_own) begin
            next_own_address_reg = AVS_WRITEDATA[7:0];
        end
        if (wr_data) begin
            next_data_reg = AVS_WRITEDATA[7:0];
        end
        if (wr_status) begin
            // Only direction, ack value and wake enable are writable
            next_bus_status_control_reg.transmit_direction = AVS_WRITEDATA[4];
            next_bus_status_control_reg.tx_ack_value = AVS_WRITEDATA[3];
            next_bus_status_control_reg.addr_match_wake_en = AVS_WRITEDATA[1];
        end
        if (wr_timeout) begin
            next_timeout_control_reg = ists_timeout_type'(AVS_WRITEDATA[7:0]);
        end

        // Subclock divided by 32 paces the timeout
        if (filt[PIN_SUB] & ~filt_d[PIN_SUB]) begin
            next_sub_div = sub_div + 5'h01;
        end
        if (!tmo_run || scl_fall) begin
            next_tmo_cnt = 7'h00;
        end else if (sub_tick && !timeout_evt) begin
            next_tmo_cnt = tmo_cnt + 7'h01;
        end

        case (state)
            ST_IDLE, ST_WAIT_STOP: begin
            end
            ST_ADDR: begin
                if (scl_rise) begin
                    next_shreg = shifted_in;
                    next_bit_cnt = bit_cnt + 4'h1;
                end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                    next_bit_cnt = 4'h0;
                    if (shreg[7:1] == own_address_reg[7:1]) begin
                        next_bus_status_control_reg.addr_match_flag = 1'b1;
                        next_bus_status_control_reg.master_read_flag = shreg[0];
                        next_bus_status_control_reg.transfer_done_flag = 1'b1;
                        next_irq = 1'b1;
                        next_wake = LOW_POWER & bus_status_control_reg.addr_match_wake_en;
                        next_tmo_run = 1'b1;
                        next_state = ST_ADDR_ACK;
                    end else begin
                        next_state = ST_WAIT_STOP;
                    end
                end
            end
            ST_ADDR_ACK, ST_RX_ACK: begin
                if (scl_fall) begin
                    next_state = ST_HOLD;
                end
            end
            ST_HOLD: begin
                // Stretch until software services the data register
                if (bus_status_control_reg.transmit_direction && wr_data) begin
                    next_shreg = AVS_WRITEDATA[7:0];
                    next_bit_cnt = 4'h0;
                    next_bus_status_control_reg.transfer_done_flag = 1'b0;
                    next_bus_status_control_reg.addr_match_flag = 1'b0;
                    next_state = ST_TX_BITS;
                end else if (!bus_status_control_reg.transmit_direction && rd_data) begin
                    next_bit_cnt = 4'h0;
                    next_bus_status_control_reg.transfer_done_flag = 1'b0;
                    next_bus_status_control_reg.addr_match_flag = 1'b0;
                    next_state = ST_RX_BITS;
                end
            end
            ST_RX_BITS: begin
                if (scl_rise) begin
                    next_shreg = shifted_in;
                    next_bit_cnt = bit_cnt + 4'h1;
                end else if (scl_fall && bit_cnt == BYTE_BITS) begin
                    next_data_reg = shreg;
                    next_bus_status_control_reg.transfer_done_flag = 1'b1;
                    next_irq = 1'b1;
                    next_state = ST_RX_ACK;
                end
            end
            ST_TX_BITS: begin
                if (scl_fall) begin
                    next_shreg = {shreg[6:0], 1'b0};
                    next_bit_cnt = bit_cnt + 4'h1;
                    if (bit_cnt + 4'h1 == BYTE_BITS) begin
                        next_state = ST_TX_ACK;
                    end
                end
            end
            ST_TX_ACK: begin
                if (scl_rise) begin
                    next_bus_status_control_reg.rx_ack_flag = filt[PIN_SDA];
                end else if (scl_fall) begin
                    next_bus_status_control_reg.transfer_done_flag = 1'b1;
                    next_irq = 1'b1;
                    // No ack: let go of SDA so the master can stop
                    next_state = bus_status_control_reg.rx_ack_flag ? ST_WAIT_STOP : ST_HOLD;
                end
            end
            default: next_state = ST_IDLE;
        endcase

        if (start_cond) begin
            next_bus_status_control_reg.bus_busy_flag = 1'b1;
            next_bus_status_control_reg.addr_match_flag = 1'b0;
            next_bus_status_control_reg.transfer_done_flag = 1'b0;
            next_bit_cnt = 4'h0;
            next_tmo_run = 1'b0;
            next_state = ST_ADDR;
        end else if (stop_cond) begin
            next_bus_status_control_reg.bus_busy_flag = 1'b0;
            next_bus_status_control_reg.addr_match_flag = 1'b0;
            next_tmo_run = 1'b0;
            next_state = ST_IDLE;
        end

        // Timeout takes precedence over bus events and status writes
        if (timeout_evt) begin
            next_tmo_run = 1'b0;
            next_tmo_cnt = 7'h00;
            next_timeout_control_reg.timeout_enable = 1'b0;
            next_timeout_control_reg.timeout_flag = 1'b1;
            next_irq = 1'b1;
            next_bus_status_control_reg = STATUS_POR;
            next_state = ST_IDLE;
        end

        // Disabled unit: flags to defaults, control bits kept
        if (!i2c_on) begin
            next_bus_status_control_reg.transfer_done_flag = STATUS_POR.transfer_done_flag;
            next_bus_status_control_reg.addr_match_flag = STATUS_POR.addr_match_flag;
            next_bus_status_control_reg.bus_busy_flag = STATUS_POR.bus_busy_flag;
            next_bus_status_control_reg.master_read_flag = STATUS_POR.master_read_flag;
            next_bus_status_control_reg.rx_ack_flag = STATUS_POR.rx_ack_flag;
            next_tmo_run = 1'b0;
            next_irq = 1'b0;
            next_wake = 1'b0;
            next_state = ST_IDLE;
        end

        // Pins only ever pulled low
        next_scl_hold = (next_state == ST_HOLD);
        case (next_state)
            ST_ADDR_ACK: next_sda_low = 1'b1;
            ST_RX_ACK: next_sda_low = ~next_bus_status_control_reg.tx_ack_value;
            ST_TX_BITS: next_sda_low = ~next_shreg[7];
            default: next_sda_low = 1'b0;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            data_reg <= 8'h00;
            own_address_reg <= OWN_ADDRESS_POR;
            mode_control_reg <= MODE_POR;
            bus_status_control_reg <= STATUS_POR;
            timeout_control_reg <= TIMEOUT_POR;
            sub_div <= 5'h00;
            tmo_cnt <= 7'h00;
            tmo_run <= 1'b0;
            scl_hold <= 1'b0;
            sda_low <= 1'b0;
            irq <= 1'b0;
            wake <= 1'b0;
        end else begin
            state <= next_state;
            bit_cnt <= next_bit_cnt;
            shreg <= next_shreg;
            data_reg <= next_data_reg;
            own_address_reg <= next_own_address_reg;
            mode_control_reg <= next_mode_control_reg;
            bus_status_control_reg <= next_bus_status_control_reg;
            timeout_control_reg <= next_timeout_control_reg;
            sub_div <= next_sub_div;
            tmo_cnt <= next_tmo_cnt;
            tmo_run <= next_tmo_run;
            scl_hold <= next_scl_hold;
            sda_low <= next_sda_low;
            irq <= next_irq;
            wake <= next_wake;
        end
    end

    assign SCL_OUT = 1'b0;
    assign SDA_OUT = 1'b0;
    assign SCL_OE = scl_hold;
    assign SDA_OE = sda_low;
    assign IRQ = irq;
    assign WAKE = wake;

endmodule // ists_slave
`default_nettype wire

// File: ists_slave_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin mismatches++; $display("mismatch %s expected %h seen %h", n, e, s); end end
module ists_slave_bench
    import ists_pkg::*;
;
    logic mclk, rst_n, rd, wr, low_power, sub_clk, ack;
    logic [4:0] addr;
    logic [31:0] wdata, rdata;
    logic waitreq, scl_oe, sda_oe, scl_out, sda_out, wake, irq, m_scl, m_sda;
    wire logic scl_w = !(m_scl | scl_oe);
    wire logic sda_w = !(m_sda | sda_oe);
    int mismatches, comparisons, irqs, wakes, el;
    logic [15:0] exp_q[$];
    logic [15:0] e;
    logic [6:0] own;
    logic [7:0] d, q;

    ists_slave u_ists_slave (.MCLK(mclk), .RST_N(rst_n), .AVS_ADDRESS(addr), .AVS_READ(rd),
        .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
        .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe), .SDA_IN(sda_w), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .SUB_CLK(sub_clk), .LOW_POWER(low_power), .WAKE(wake), .IRQ(irq));
    ists_i2c_master u_ists_i2c_master (.mclk(mclk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl),
        .sda_low(m_sda));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = !mclk;
    end
    // Offset start keeps subclock edges away from system clock edges
    initial begin
        sub_clk = 1'b0;
        #3;
        forever #80 sub_clk = !sub_clk;
    end
    // Edge sampling sees what stood before the edge, as the design does
    always @(posedge mclk) begin
        irqs += int'(irq === 1'b1);
        wakes += int'(wake === 1'b1);
        if (rd === 1'b1 && waitreq === 1'b0 && exp_q.size() > 0) begin
            e = exp_q.pop_front();
            `CHK("readdata", e[7:0] & e[15:8], rdata[7:0] & e[15:8])
        end
    end
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] v,
            input logic [7:0] m = 8'hff);
        @(posedge mclk);
        if (!w) exp_q.push_back({m, v});
        addr <= a;
        wdata <= {24'h0, v};
        rd <= !w;
        wr <= w;
        // Held until an edge samples waitrequest low; that edge takes the answer
        do @(posedge mclk); while (waitreq !== 1'b0);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic test_done();
        if (mismatches == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge mclk);
        mismatches++;
        test_done();
    end
    initial begin
        {rst_n, rd, wr, addr, wdata, low_power} = '0;
        {mismatches, comparisons, irqs, wakes} = '0;
        void'($urandom(71317));
        repeat (10) @(posedge mclk);
        rst_n <= 1'b1;
        own = 7'($urandom_range(126, 1));
        bus(0, ADDR_BUS_STATUS, 8'h81);
        bus(0, ADDR_MODE_CONTROL, 8'he0);
        bus(0, 5'h14, 8'h00);
        bus(1, ADDR_OWN_ADDRESS, {own, 1'b0});
        for (int k = 0; k < 4; k++) begin
            bus(1, ADDR_MODE_CONTROL, 8'hc2 | 8'(k << 2));
            low_power <= k[0];
            bus(1, ADDR_BUS_STATUS, {6'h0, k[1], 1'b0});
            d = 8'($urandom);
            u_ists_i2c_master.start();
            u_ists_i2c_master.xbyte({own, 1'b0}, 1'b1, q, ack);
            `CHK("addr_ack", 1'b0, ack)
            `CHK("wakes", int'(k == 3), wakes)
            `CHK("irqs", 2 * k + 1, irqs)
            bus(0, ADDR_BUS_STATUS, {3'h7, 3'h0, k[1], 1'b0}, 8'hfe);
            bus(1, ADDR_BUS_STATUS, {4'h0, k[0], 3'h0});
            bus(0, ADDR_SHARED_DATA, 8'h00, 8'h00);
            u_ists_i2c_master.xbyte(d, 1'b1, q, ack);
            `CHK("data_ack", k[0], ack)
            `CHK("irqs", 2 * k + 2, irqs)
            bus(0, ADDR_SHARED_DATA, d);
            u_ists_i2c_master.stop();
            bus(0, ADDR_BUS_STATUS, 8'h00, 8'h20);
        end
        for (int j = 0; j < 7; j += 6) begin
            u_ists_i2c_master.start();
            u_ists_i2c_master.xbyte({own ^ 7'(1 << j), 1'b0}, 1'b1, q, ack);
            `CHK("stranger_ack", 1'b1, ack)
            `CHK("irqs", 8, irqs)
            u_ists_i2c_master.stop();
        end
        u_ists_i2c_master.start();
        u_ists_i2c_master.xbyte({own, 1'b1}, 1'b1, q, ack);
        bus(0, ADDR_BUS_STATUS, 8'h04, 8'h04);
        bus(1, ADDR_BUS_STATUS, 8'h10);
        for (int j = 0; j < 2; j++) begin
            d = 8'($urandom);
            bus(1, ADDR_SHARED_DATA, d);
            u_ists_i2c_master.xbyte(8'hff, 1'(j), q, ack);
            `CHK("tx_byte", d, q)
            bus(0, ADDR_BUS_STATUS, 8'(j), 8'h01);
        end
        `CHK("sda_free", 1'b0, sda_oe)
        u_ists_i2c_master.stop();
        bus(1, ADDR_TIMEOUT_CONTROL, 8'h83);
        u_ists_i2c_master.start();
        u_ists_i2c_master.xbyte({own, 1'b0}, 1'b1, q, ack);
        for (el = 0; el < 3000 && irqs < 13; el++) @(posedge mclk);
        `CHK("timeout_window", 1'b1, el >= 740 && el <= 1060)
        bus(0, ADDR_TIMEOUT_CONTROL, 8'h43);
        bus(0, ADDR_BUS_STATUS, 8'h81);
        bus(0, ADDR_OWN_ADDRESS, {own, 1'b0});
        bus(0, ADDR_MODE_CONTROL, 8'hce);
        `CHK("scl_free", 1'b0, scl_oe)
        bus(1, ADDR_TIMEOUT_CONTROL, 8'h03);
        bus(0, ADDR_TIMEOUT_CONTROL, 8'h03);
        u_ists_i2c_master.stop();
        test_done();
    end
endmodule // ists_slave_bench
`default_nettype wire
